// >>> hdl/irq_ack_pkg.sv
// constants and types for the interrupt acknowledgment delay logic
package irq_ack_pkg;
   // interrupt sources, address width, stack depth
   localparam int unsigned SRC_N      = 13;
   localparam int unsigned SRC_W      = 4;
   localparam int unsigned ADDR_W     = 16;
   localparam int unsigned SP_W       = 4;
   localparam int unsigned RAS_DEPTH  = 16;
   localparam int unsigned EIR_W      = 16;
   // enable shift register layout
   localparam int unsigned EIR_GDIS_BIT = 15;
   localparam logic [EIR_W-1:0] EIR_RESET = 16'hFFFF;
   localparam logic [0:0]       EIR_FILL  = 1'h1;
   // reset values and stack pointer step
   localparam logic [SP_W-1:0]   SP_RESET = 4'h0;
   localparam logic [SP_W-1:0]   SP_STEP  = 4'h1;
   localparam logic [ADDR_W-1:0] PC_RESET = 16'h0000;
   // vector table placement, spacing in words
   localparam logic [ADDR_W-1:0] VEC_BASE  = 16'h0100;
   localparam int unsigned       VEC_SHIFT = 2;
   // delay lengths in instruction cycles
   localparam logic [1:0] DLY_NONE = 2'h0;
   localparam logic [1:0] DLY_ONE  = 2'h1;
   localparam logic [1:0] DLY_TWO  = 2'h2;

   // class of the instruction in decode
   typedef enum logic [3:0] {
      CLS_OTHER   = 4'h0,
      CLS_JMP_U   = 4'h1,
      CLS_CALL_U  = 4'h2,
      CLS_RET_U   = 4'h3,
      CLS_RETURN_FROM_INTERRUPT_U  = 4'h4,
      CLS_FLUSH   = 4'h5,
      CLS_JMP_C   = 4'h6,
      CLS_CALL_C  = 4'h7,
      CLS_RET_C   = 4'h8,
      CLS_RETURN_FROM_INTERRUPT_C  = 4'h9,
      CLS_JMP_IND = 4'hA,
      CLS_CAL_IND = 4'hB,
      CLS_ITERATE = 4'hC,
      CLS_LOOP    = 4'hD
   } instr_class_t;
endpackage

// >>> hdl/interrupt_ack_delay_logic.sv
// interrupt acknowledgment gating, delay counting and context update
// Summary of operation
// R01 - sp, return address stack and pc are updated by hardware on acknowledgment
// R02 - acknowledgment waits while stack or pc touching instructions are in progress
// R03 - branch to the service routine itself costs a single delay cycle
// R04 - no acknowledgment during a repeat; request stays pending
// R05 - no acknowledgment while peripheral io wait stretches an access
// R06 - no acknowledgment during external memory wait cycles
// R07 - unconditional immediate jump decode delays acknowledgment one cycle
// R08 - unconditional immediate call decode delays acknowledgment one cycle
// R09 - unconditional return decode delays acknowledgment one cycle
// R10 - unconditional interrupt return decode delays acknowledgment one cycle
// R11 - flush instruction decode delays acknowledgment one cycle
// R12 - fetch of loop end instruction delays acknowledgment one cycle
// R13 - conditional immediate jump decode delays acknowledgment two cycles
// R14 - conditional immediate call decode delays acknowledgment two cycles
// R15 - conditional return decode delays acknowledgment two cycles
// R16 - conditional interrupt return decode delays acknowledgment two cycles
// R17 - register indirect jump decode delays acknowledgment two cycles
// R18 - register indirect call decode delays acknowledgment two cycles
// R19 - single instruction iterate setup decode delays acknowledgment two cycles
// R20 - loop setup decode delays acknowledgment two cycles
// R21 - service routine first fetch is held while the delay is active
// R22 - on acknowledgment shift enables right, disable, push address, load vector
// R23 - on return restore pc, pop sp, shift enables left
// R24 - overlapping delays keep the longest; acknowledge on first clear cycle
`timescale 1ns/10ps
module interrupt_ack_delay_logic
   import irq_ack_pkg::*;
(
   // clock, reset, enable
   input  wire logic                sys_clk_i,
   input  wire logic                resetn_i,
   input  wire logic                clk_en_i,
   // interrupt sources
   input  wire logic [SRC_N-1:0]    irq_req_i,
   // pipeline status
   input  wire logic                instr_step_i,
   input  wire logic [3:0]          dec_class_i,
   input  wire logic                loop_end_fetch_i,
   input  wire logic                io_wait_i,
   input  wire logic                mem_wait_i,
   input  wire logic                iterate_busy_i,
   input  wire logic [ADDR_W-1:0]   pending_pc_i,
   input  wire logic                return_from_interrupt_exec_i,
   // enable register transfer
   input  wire logic                eir_wr_i,
   input  wire logic [EIR_W-1:0]    eir_wdata_i,
   // acknowledgment and context
   output logic                     ack_o,
   output logic [SRC_W-1:0]         ack_src_o,
   output logic                     ack_hold_o,
   output logic                     pc_load_o,
   output logic [ADDR_W-1:0]        pc_target_o,
   output logic [SP_W-1:0]          sp_o,
   output logic [EIR_W-1:0]         eir_o,
   output logic [SRC_N-1:0]         pending_o
);

   // delay length of the decoded class
   function automatic logic [1:0] class_delay(input logic [3:0] cls);
      logic [1:0] d;
      d = DLY_NONE;
      case (cls)
         CLS_JMP_U, CLS_CALL_U, CLS_RET_U,
         CLS_RETURN_FROM_INTERRUPT_U, CLS_FLUSH:            d = DLY_ONE; // [R07] [R08] [R09] [R10] [R11]
         CLS_JMP_C, CLS_CALL_C, CLS_RET_C,
         CLS_RETURN_FROM_INTERRUPT_C:                       d = DLY_TWO; // [R13] [R14] [R15] [R16]
         CLS_JMP_IND, CLS_CAL_IND:         d = DLY_TWO; // [R17] [R18]
         CLS_ITERATE, CLS_LOOP:            d = DLY_TWO; // [R19] [R20]
         default:                          d = DLY_NONE;
      endcase
      return d;
   endfunction

   // lowest numbered enabled pending source
   function automatic logic [SRC_W-1:0] pick_src(input logic [SRC_N-1:0] req);
      logic [SRC_W-1:0] s;
      s = '0;
      for (int i = SRC_N - 1; i >= 0; i--) begin
         if (req[i]) begin
            s = SRC_W'(i);
         end
      end
      return s;
   endfunction

   logic [1:0]          delay_q;
   logic [1:0]          delay_d;
   logic [1:0]          new_dly;
   logic [1:0]          left_dly;
   logic                blocked;
   logic [SRC_N-1:0]    enabled;
   logic [SRC_N-1:0]    pend_q;
   logic                take;
   logic [SRC_W-1:0]    take_src;
   logic                flush;
   logic [SP_W-1:0]     sp_q;
   logic [SP_W-1:0]     sp_up;
   logic [EIR_W-1:0]    eir_q;
   logic [ADDR_W-1:0]   ras_q [RAS_DEPTH];
   logic                ack_q;
   logic [SRC_W-1:0]    ack_src_q;
   logic                hold_q;
   logic                pc_load_q;
   logic [ADDR_W-1:0]   pc_q;

   // per source enable: a set bit disables the source
   genvar g;
   generate
      for (g = 0; g < SRC_N; g++) begin : g_en
         assign enabled[g] = pend_q[g] & ~eir_q[SRC_N-1-g];
      end
   endgenerate

   // delay bookkeeping for this instruction step
   always_comb begin
      new_dly = class_delay(dec_class_i);
      if (loop_end_fetch_i && (new_dly == DLY_NONE)) begin
         new_dly = DLY_ONE; // [R12]
      end
      left_dly = (delay_q != DLY_NONE) ? delay_q - DLY_ONE : DLY_NONE;
      // longest remaining delay wins
      delay_d  = (new_dly - DLY_ONE > left_dly && new_dly != DLY_NONE) ?
                 new_dly - DLY_ONE : left_dly; // [R24]
      // hold conditions and delays in force this cycle
      blocked  = io_wait_i | mem_wait_i | iterate_busy_i         // [R04] [R05] [R06]
               | (delay_q != DLY_NONE) | (new_dly != DLY_NONE)   // [R02]
               | return_from_interrupt_exec_i | ack_q;                            // [R03]
      flush    = instr_step_i && (dec_class_i == CLS_FLUSH);
      take_src = pick_src(enabled);
      take     = instr_step_i && !blocked && !eir_q[EIR_GDIS_BIT] && (|enabled); // [R24]
      sp_up    = sp_q + SP_STEP;
   end

   // remaining delay cycles, counted in instruction steps
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         delay_q <= DLY_NONE;
      end else if (clk_en_i && instr_step_i) begin
         delay_q <= delay_d; // [R13] [R24]
      end
   end

   // recorded requests: a new request wins over ack or flush clearing
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pend_q <= '0;
      end else if (clk_en_i) begin
         for (int i = 0; i < SRC_N; i++) begin
            if (irq_req_i[i]) begin
               pend_q[i] <= 1'b1;
            end else if (flush || (take && take_src == SRC_W'(i))) begin
               pend_q[i] <= 1'b0; // [R04] [R11]
            end
         end
      end
   end

   // enable shift register: right on ack, left on return
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         eir_q <= EIR_RESET;
      end else if (clk_en_i) begin
         if (take) begin
            eir_q <= {1'b1, eir_q[EIR_W-1:1]}; // [R22]
         end else if (return_from_interrupt_exec_i) begin
            eir_q <= {eir_q[EIR_W-2:0], EIR_FILL}; // [R23]
         end else if (eir_wr_i) begin
            eir_q <= eir_wdata_i;
         end
      end
   end

   // stack pointer
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sp_q <= SP_RESET;
      end else if (clk_en_i) begin
         if (take) begin
            sp_q <= sp_up; // [R01] [R22]
         end else if (return_from_interrupt_exec_i) begin
            sp_q <= sp_q - SP_STEP; // [R23]
         end
      end
   end

   // return address stack storage
   always_ff @(posedge sys_clk_i) begin
      if (clk_en_i && take) begin
         ras_q[sp_up] <= pending_pc_i; // [R01] [R22]
      end
   end

   // pc redirect to vector or saved return address
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pc_load_q <= 1'b0;
         pc_q      <= PC_RESET;
      end else if (clk_en_i) begin
         pc_load_q <= take | return_from_interrupt_exec_i;
         if (take) begin
            pc_q <= VEC_BASE + (ADDR_W'(take_src) << VEC_SHIFT); // [R22]
         end else if (return_from_interrupt_exec_i) begin
            pc_q <= ras_q[sp_q]; // [R23]
         end
      end
   end

   // acknowledgment pulse and delay signal
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ack_q     <= 1'b0;
         ack_src_q <= '0;
         hold_q    <= 1'b0;
      end else if (clk_en_i) begin
         ack_q  <= take;
         hold_q <= (delay_d != DLY_NONE) | (instr_step_i & new_dly != DLY_NONE); // [R21]
         if (take) begin
            ack_src_q <= take_src;
         end
      end
   end

   assign ack_o       = ack_q;
   assign ack_src_o   = ack_src_q;
   assign ack_hold_o  = hold_q;
   assign pc_load_o   = pc_load_q;
   assign pc_target_o = pc_q;
   assign sp_o        = sp_q;
   assign eir_o       = eir_q;
   assign pending_o   = pend_q;

   // checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);

   iterate_hold_a: assert property (clk_en_i && iterate_busy_i |=> !ack_o) // [R04]
      else $error("ack during iterate");
   io_wait_hold_a: assert property (clk_en_i && io_wait_i |=> !ack_o) // [R05]
      else $error("ack during io wait");
   mem_wait_hold_a: assert property (clk_en_i && mem_wait_i |=> !ack_o) // [R06]
      else $error("ack during memory wait");
   one_cycle_dly_a: assert property (clk_en_i && instr_step_i
         && class_delay(dec_class_i) == DLY_ONE |=> !ack_o) // [R07]
      else $error("ack in decode cycle of one cycle class");
   two_cycle_dly_a: assert property (clk_en_i && instr_step_i
         && class_delay(dec_class_i) == DLY_TWO |=> delay_q != DLY_NONE) // [R13]
      else $error("two cycle delay not armed");
   loop_end_dly_a: assert property (clk_en_i && instr_step_i && loop_end_fetch_i
         |=> !ack_o) // [R12]
      else $error("ack on loop end fetch");
   ack_push_a: assert property (ack_o && $past(clk_en_i) |-> sp_o == $past(sp_o) + SP_STEP
         && eir_o[EIR_GDIS_BIT] && pc_load_o) // [R22]
      else $error("ack context update wrong");
   return_from_interrupt_pop_a: assert property (clk_en_i && return_from_interrupt_exec_i && !take
         |=> sp_o == $past(sp_o) - SP_STEP && eir_o[0] && pc_load_o) // [R23]
      else $error("return context update wrong");
   delay_blocks_a: assert property (ack_hold_o |-> !ack_o) // [R21]
      else $error("ack while delay signal active");
   single_ack_a: assert property (ack_o |=> !ack_o) // [R03]
      else $error("back to back ack");
   pending_kept_a: assert property (clk_en_i && $rose(pend_q[0]) && eir_q[EIR_GDIS_BIT]
         && !eir_wr_i && !return_from_interrupt_exec_i && !flush |=> pend_q[0]) // [R04]
      else $error("pending request lost");

   ack_seen_c:   cover property (ack_o);
   ack_after2_c: cover property (instr_step_i && class_delay(dec_class_i) == DLY_TWO
         ##[1:20] ack_o);
   return_from_interrupt_c:       cover property (return_from_interrupt_exec_i ##1 pc_load_o);
   nested_c:     cover property (ack_o ##[1:50] ack_o);

endmodule

// >>> testbench/irq_source_model.sv
// request source model: raise command replayed on the request lines one cycle later
`timescale 1ns/10ps
module irq_source_model
   import irq_ack_pkg::*;
(
   // clock
   input  wire logic             sys_clk_i,
   // raise command and request lines
   input  wire logic [SRC_N-1:0] raise_i,
   output logic      [SRC_N-1:0] irq_req_o
);
   logic [SRC_N-1:0] cmd_q;
   initial cmd_q = '0;
   initial irq_req_o = '0;
   // capture the command, drive it mid-cycle for as long as it is held
   always @(posedge sys_clk_i) cmd_q <= raise_i;
   always @(negedge sys_clk_i) irq_req_o <= cmd_q;
endmodule

// >>> testbench/interrupt_ack_delay_logic_test.sv
// self-checking bench for the interrupt acknowledgment delay logic
`timescale 1ns/10ps
module interrupt_ack_delay_logic_test
   import irq_ack_pkg::*;
;
   typedef struct {
      logic [3:0]       c0, c1;
      logic             le;
      logic [SRC_N-1:0] pre, sim, rest;
      int               n;
      logic [SRC_W-1:0] src;
   } row_t;
   logic sys_clk_i = 0, resetn_i = 0, instr_step_i = 0, loop_end_fetch_i = 0;
   logic io_wait_i = 0, mem_wait_i = 0, iterate_busy_i = 0, return_from_interrupt_exec_i = 0, eir_wr_i = 0;
   logic [3:0]        dec_class_i = 4'h0;
   logic [ADDR_W-1:0] pending_pc_i = 16'h0000, pc_target_o;
   logic [EIR_W-1:0]  eir_wdata_i = 16'h0000, eir_o;
   logic [SRC_N-1:0]  raise = '0, irq_req, pending_o;
   logic [SRC_W-1:0]  ack_src_o;
   logic [SP_W-1:0]   sp_o, sp_exp = 4'h0;
   logic              ack_o, ack_hold_o, pc_load_o;
   int                failures = 0, samples_checked = 0;
   row_t              rows [18];
   // clock at 125 MHz
   initial forever #4 sys_clk_i = ~sys_clk_i;
   irq_source_model u_src (.sys_clk_i(sys_clk_i), .raise_i(raise), .irq_req_o(irq_req));
   interrupt_ack_delay_logic u_dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
      .clk_en_i(1'b1), .irq_req_i(irq_req), .instr_step_i(instr_step_i),
      .dec_class_i(dec_class_i), .loop_end_fetch_i(loop_end_fetch_i), .io_wait_i(io_wait_i),
      .mem_wait_i(mem_wait_i), .iterate_busy_i(iterate_busy_i), .pending_pc_i(pending_pc_i),
      .return_from_interrupt_exec_i(return_from_interrupt_exec_i), .eir_wr_i(eir_wr_i), .eir_wdata_i(eir_wdata_i),
      .ack_o(ack_o), .ack_src_o(ack_src_o), .ack_hold_o(ack_hold_o), .pc_load_o(pc_load_o),
      .pc_target_o(pc_target_o), .sp_o(sp_o), .eir_o(eir_o), .pending_o(pending_o));
   // compare and count
   task automatic check(input string nm, input logic [15:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // acknowledge just seen: context pushed, vector loaded
   task automatic ack_seen(input logic [SRC_W-1:0] src);
      instr_step_i = 0;
      check("src", 16'(ack_src_o), 16'(src));
      check("load", 16'(pc_load_o), 16'h0001);
      check("vec", pc_target_o, VEC_BASE + (16'(src) << VEC_SHIFT));
      check("eir", eir_o, 16'h8000);
      check("sp", 16'(sp_o), 16'(sp_exp + SP_STEP));
   endtask
   // return from interrupt, one-cycle pulse
   task automatic do_return_from_interrupt();
      int k;
      return_from_interrupt_exec_i = 1;
      @(negedge sys_clk_i);
      return_from_interrupt_exec_i = 0;
      for (k = 0; pc_load_o !== 1'b1 && k < 4; k++) @(negedge sys_clk_i);
      check("rpc", pc_target_o, {12'h120, sp_exp});
      check("reir", eir_o, 16'h0001);
      check("rsp", 16'(sp_o), 16'(sp_exp));
      if (k == 4) begin
         failures++;
         finish_test();
      end
   endtask
   // one instruction sequence with a request pending
   task automatic run_row(input row_t r);
      int k;
      @(negedge sys_clk_i);
      raise = r.pre;
      pending_pc_i = {12'h120, sp_exp};
      @(negedge sys_clk_i);
      raise = r.sim;
      @(negedge sys_clk_i);
      raise = '0;
      instr_step_i = 1;
      dec_class_i = r.c0;
      loop_end_fetch_i = r.le;
      k = 0;
      do begin
         @(negedge sys_clk_i);
         k++;
         if (k == 1 && r.n == 3) check("hold", 16'(ack_hold_o), 16'h0001);
         dec_class_i = (k == 1) ? r.c1 : CLS_OTHER;
         loop_end_fetch_i = 0;
      end while (ack_o !== 1'b1 && k < 8);
      check("edges", 16'(k), 16'(r.n));
      if (k == 8) finish_test();
      ack_seen(r.src);
      check("pend", 16'(pending_o), 16'(r.rest));
      do_return_from_interrupt();
   endtask
   initial begin
      // uniform rows: class k then plain steps
      for (int k = 0; k < 14; k++) begin
         rows[k] = '{4'(k), CLS_OTHER, 0, 13'h0001, 0, 0, (k == 0) ? 1 : (k < 6) ? 2 : 3, 0};
      end
      rows[5]  = '{CLS_FLUSH, CLS_OTHER, 0, 13'h0008, 13'h0001, 0, 2, 0};
      rows[14] = '{CLS_OTHER, CLS_OTHER, 1, 13'h0001, 0, 0, 2, 0};
      rows[15] = '{CLS_JMP_U, CLS_JMP_C, 0, 13'h0001, 0, 0, 4, 0};
      rows[16] = '{CLS_JMP_C, CLS_JMP_U, 0, 13'h0001, 0, 0, 3, 0};
      rows[17] = '{CLS_OTHER, CLS_OTHER, 0, 13'h0028, 0, 13'h0020, 1, 4'h3};
      repeat (12) @(posedge sys_clk_i);
      check("reir", eir_o, EIR_RESET);
      check("rsp", 16'(sp_o), 16'(SP_RESET));
      check("rpend", 16'(pending_o), 16'h0000);
      @(negedge sys_clk_i);
      resetn_i = 1;
      eir_wr_i = 1;
      @(negedge sys_clk_i);
      eir_wr_i = 0;
      check("wr", eir_o, 16'h0000);
      foreach (rows[i]) run_row(rows[i]);
      // held requests: io wait, memory wait, iterate
      for (int w = 0; w < 3; w++) begin
         @(negedge sys_clk_i);
         raise = 13'h0001;
         pending_pc_i = {12'h120, sp_exp};
         {io_wait_i, mem_wait_i, iterate_busy_i} = 3'b100 >> w;
         @(negedge sys_clk_i);
         raise = '0;
         instr_step_i = 1;
         repeat (4) begin
            @(negedge sys_clk_i);
            check("held", 16'(ack_o), 16'h0000);
         end
         check("kept", 16'(pending_o[0]), 16'h0001);
         {io_wait_i, mem_wait_i, iterate_busy_i} = 3'b000;
         @(negedge sys_clk_i);
         check("free", 16'(ack_o), 16'h0001);
         ack_seen(4'h0);
         do_return_from_interrupt();
      end
      finish_test();
   end
endmodule
